/* File: logic/pbac_pkg.sv */
// Shared constants for the peripheral bridge abort and access control block
`default_nettype none
package pbac_pkg;
  // Register byte offsets
  localparam logic [7:0] CAPTURE_OFF = 8'h1c;
  localparam logic [7:0] ACCESS_OFF = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h28;
  // Capture register fields
  localparam int ABORT_FLAG_BIT = 0;
  localparam int MISMATCH_FLAG_BIT = 1;
  localparam int DIRECTION_BIT = 2;
  localparam int INITIATOR_LSB = 9;
  localparam int INITIATOR_MSB = 10;
  localparam int SPARE_LSB = 11;
  localparam int SPARE_MSB = 15;
  // Access control fields
  localparam int DMA_ENABLE_BIT = 0;
  localparam int DMA_MASK_BIT = 1;
  localparam int IC_MASK_BIT = 2;
  localparam int DPS_ENABLE_BIT = 3;
  localparam int ACCESS_USED_MSB = 3;
  // Interrupt status and mask fields
  localparam int IRQ_ABORT_BIT = 0;
  localparam int IRQ_MISMATCH_BIT = 1;
  // Reset values
  localparam logic [3:0] ACCESS_RESET = 4'h1;
  localparam logic DIRECTION_RESET = 1'b1;
  localparam logic [1:0] INITIATOR_RESET = 2'h0;
  localparam logic [4:0] SPARE_RESET = 5'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // Initiator codes
  localparam logic [1:0] INIT_CPU = 2'h0;
  localparam logic [1:0] INIT_DMA = 2'h1;
  localparam logic [1:0] INIT_IC = 2'h2;
  localparam logic [1:0] INIT_INVALID = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pbac_pkg
`default_nettype wire

/* File: logic/pbac_event_if.sv */
// Capture event carrier from the access monitor to the register file
`timescale 1ns/1ps
`default_nettype none
interface pbac_event_if;
  logic evtValid;
  logic evtAbort;
  logic evtMismatch;
  logic evtRead;
  logic [1:0] evtInit;
  modport source (
    output evtValid,
    output evtAbort,
    output evtMismatch,
    output evtRead,
    output evtInit
  );
  modport sink (
    input evtValid,
    input evtAbort,
    input evtMismatch,
    input evtRead,
    input evtInit
  );
endinterface : pbac_event_if
`default_nettype wire

/* File: logic/pbac_access_monitor.sv */
// Access monitor: detects aborts and size mismatches, routes abort answers
`timescale 1ns/1ps
`default_nettype none
module pbac_access_monitor
  import pbac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bridge access report
  input wire logic accDone,
  input wire logic accAbort,
  input wire logic accRead,
  input wire logic [1:0] accInit,
  input wire logic [1:0] memSize,
  input wire logic [1:0] periphSize,
  // Controls
  input wire logic dmaEnable,
  input wire logic dmaMask,
  input wire logic icMask,
  // Abort answers
  output logic cpuAbortResp,
  output logic dmaAbortResp,
  output logic icAbortResp,
  // Capture event
  pbac_event_if.source evt
);
  // 1x both mean 32 bits
  function automatic logic [1:0] sizeNorm(input logic [1:0] s);
    sizeNorm = s[1] ? 2'h2 : s;
  endfunction : sizeNorm

  wire logic fromDma = accInit == INIT_DMA;
  wire logic dmaBlocked = accDone & fromDma & ~dmaEnable;
  wire logic isAbort = (accDone & accAbort) | dmaBlocked;
  wire logic isMismatch = accDone & ~dmaBlocked &
    (sizeNorm(memSize) != sizeNorm(periphSize));

  always_ff @(posedge clock) begin
    if (reset) begin
      cpuAbortResp <= 1'b0;
      dmaAbortResp <= 1'b0;
      icAbortResp <= 1'b0;
      evt.evtValid <= 1'b0;
      evt.evtAbort <= 1'b0;
      evt.evtMismatch <= 1'b0;
      evt.evtRead <= 1'b0;
      evt.evtInit <= INITIATOR_RESET;
    end else begin
      cpuAbortResp <= isAbort & (accInit == INIT_CPU);
      dmaAbortResp <= isAbort & fromDma & ~dmaMask;
      icAbortResp <= isAbort & (accInit == INIT_IC) & ~icMask;
      evt.evtValid <= isAbort | isMismatch;
      evt.evtAbort <= isAbort;
      evt.evtMismatch <= isMismatch;
      evt.evtRead <= accRead;
      evt.evtInit <= accInit;
    end
  end
endmodule : pbac_access_monitor
`default_nettype wire

/* File: logic/pbac_irq_unit.sv */
// Sticky interrupt status, cleared by read, gated by mask
`timescale 1ns/1ps
`default_nettype none
module pbac_irq_unit
  import pbac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Events and software access
  input wire logic [1:0] setBits,
  input wire logic readClear,
  input wire logic [1:0] mask,
  // State
  output logic [1:0] status,
  output logic irq
);
  wire logic [1:0] status_nxt = setBits | (status & {2{~readClear}});

  always_ff @(posedge clock) begin
    if (reset) begin
      status <= 2'h0;
      irq <= 1'b0;
    end else begin
      status <= status_nxt;
      irq <= |(status_nxt & mask);
    end
  end
endmodule : pbac_irq_unit
`default_nettype wire

/* File: logic/pbac_bridge_ctrl.sv */
// What this block does
// - A sticky flag is set when memory and peripheral access sizes differ, and a read of it returns then clears it.
// - A sticky flag is set whenever a peripheral bus access is aborted, and a read clears it.
// - On an abort or size mismatch the transaction direction is captured, 0 for write and 1 for read.
// - A power-saving bit, reset to 0, lets the bridge clock be gated dynamically when set.
// - When its mask bit is set, an abort for the interconnect initiator port is withheld; reset 0.
// - When its mask bit is set, an abort for a system DMA access is withheld, else returned; reset 0.
// - A DMA access bit, reset to 1, lets the system DMA reach peripherals, and blocks it when cleared.
// - On an abort a two-bit initiator code is recorded: 00 core, 01 DMA, 10 interconnect, 11 invalid.
`timescale 1ns/1ps
`default_nettype none
module pbac_bridge_ctrl
  import pbac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Bridge access report
  input wire logic accDone,
  input wire logic accAbort,
  input wire logic accRead,
  input wire logic [1:0] accInit,
  input wire logic [1:0] memSize,
  input wire logic [1:0] periphSize,
  input wire logic accBusy,
  // Abort answers to initiators
  output logic cpuAbortResp,
  output logic dmaAbortResp,
  output logic icAbortResp,
  // Access and clock control
  output logic dmaAccessEnable,
  output logic bridgeClockRun,
  // Interrupt
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////
  // Types and state

  typedef enum logic {
    WR_COLLECT,
    WR_RESPOND
  } pbac_wr_state_e;
  typedef enum logic {
    RD_IDLE,
    RD_RESPOND
  } pbac_rd_state_e;
  pbac_wr_state_e wrState_r;
  pbac_wr_state_e wrState_nxt;
  pbac_rd_state_e rdState_r;
  pbac_rd_state_e rdState_nxt;

  // Held write address and data
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;

  // Registers
  logic [ACCESS_USED_MSB:0] access_r;
  logic [ACCESS_USED_MSB:0] access_nxt;
  logic abortFlag_r;
  logic mismatchFlag_r;
  logic direction_r;
  logic [1:0] initiator_r;
  logic [4:0] spare_r;
  logic [4:0] spare_nxt;
  logic [1:0] irqMask_r;
  logic [1:0] irqMask_nxt;
  logic [1:0] irqStatus;

  pbac_event_if evtBus ();

  //////////////////////////////////////////////////////////////////////////
  // Register decode

  wire logic awTake = s_axi_awvalid & s_axi_awready;
  wire logic wTake = s_axi_wvalid & s_axi_wready;
  wire logic arTake = s_axi_arvalid & s_axi_arready;

  wire logic [7:0] wrAddr = awTake ? s_axi_awaddr : awAddr_r;
  wire logic [31:0] wrData = wTake ? s_axi_wdata : wData_r;
  wire logic [3:0] wrStrb = wTake ? s_axi_wstrb : wStrb_r;
  wire logic haveAw = awHeld_r | awTake;
  wire logic haveW = wHeld_r | wTake;
  wire logic doWrite = (wrState_r == WR_COLLECT) & haveAw & haveW;

  wire logic wrCapture = wrAddr == CAPTURE_OFF;
  wire logic wrAccess = wrAddr == ACCESS_OFF;
  wire logic wrIrqStatus = wrAddr == IRQ_STATUS_OFF;
  wire logic wrIrqMask = wrAddr == IRQ_MASK_OFF;
  wire logic wrMapped = wrCapture | wrAccess | wrIrqStatus | wrIrqMask;

  wire logic rdCapture = s_axi_araddr == CAPTURE_OFF;
  wire logic rdAccess = s_axi_araddr == ACCESS_OFF;
  wire logic rdIrqStatus = s_axi_araddr == IRQ_STATUS_OFF;
  wire logic rdIrqMask = s_axi_araddr == IRQ_MASK_OFF;
  wire logic rdMapped = rdCapture | rdAccess | rdIrqStatus | rdIrqMask;

  // Read side effects happen at the address handshake
  wire logic captureReadClr = arTake & rdCapture;
  wire logic irqReadClr = arTake & rdIrqStatus;

  //////////////////////////////////////////////////////////////////////////
  // Register read view

  wire logic [15:0] captureView = {
    spare_r,
    initiator_r,
    6'h00,
    direction_r,
    mismatchFlag_r,
    abortFlag_r
  };
  wire logic [15:0] accessView = {12'h000, access_r};
  wire logic [15:0] irqStatusView = {14'h0000, irqStatus};
  wire logic [15:0] irqMaskView = {14'h0000, irqMask_r};

  wire logic [15:0] rdView =
    rdCapture ? captureView :
    rdAccess ? accessView :
    rdIrqStatus ? irqStatusView :
    rdIrqMask ? irqMaskView : 16'h0000;

  //////////////////////////////////////////////////////////////////////////
  // Register write values

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    laneMerge[7:0] = strb[0] ? data[7:0] : old[7:0];
    laneMerge[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction : laneMerge

  wire logic [15:0] accessMerged = laneMerge(accessView, wrData, wrStrb);
  wire logic [15:0] captureMerged = laneMerge(captureView, wrData, wrStrb);
  wire logic [15:0] maskMerged = laneMerge(irqMaskView, wrData, wrStrb);

  assign access_nxt = (doWrite & wrAccess) ?
    accessMerged[ACCESS_USED_MSB:0] : access_r;
  assign spare_nxt = (doWrite & wrCapture) ?
    captureMerged[SPARE_MSB:SPARE_LSB] : spare_r;
  assign irqMask_nxt = (doWrite & wrIrqMask) ? maskMerged[1:0] : irqMask_r;

  //////////////////////////////////////////////////////////////////////////
  // Bus state machines

  always_comb begin
    wrState_nxt = wrState_r;
    case (wrState_r)
      WR_COLLECT: begin
        if (doWrite) begin
          wrState_nxt = WR_RESPOND;
        end
      end
      WR_RESPOND: begin
        if (s_axi_bready) begin
          wrState_nxt = WR_COLLECT;
        end
      end
      default: begin
        wrState_nxt = WR_COLLECT;
      end
    endcase
  end

  always_comb begin
    rdState_nxt = rdState_r;
    case (rdState_r)
      RD_IDLE: begin
        if (arTake) begin
          rdState_nxt = RD_RESPOND;
        end
      end
      RD_RESPOND: begin
        if (s_axi_rready) begin
          rdState_nxt = RD_IDLE;
        end
      end
      default: begin
        rdState_nxt = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wrState_r <= WR_COLLECT;
      rdState_r <= RD_IDLE;
    end else begin
      wrState_r <= wrState_nxt;
      rdState_r <= rdState_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write channel

  always_ff @(posedge clock) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else begin
      awHeld_r <= haveAw & ~doWrite;
      wHeld_r <= haveW & ~doWrite;
      if (awTake) begin
        awAddr_r <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= (wrState_nxt == WR_COLLECT) & ~(haveAw & ~doWrite);
      s_axi_wready <= (wrState_nxt == WR_COLLECT) & ~(haveW & ~doWrite);
      s_axi_bvalid <= wrState_nxt == WR_RESPOND;
      if (doWrite) begin
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read channel

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= rdState_nxt == RD_IDLE;
      s_axi_rvalid <= rdState_nxt == RD_RESPOND;
      if (arTake) begin
        s_axi_rdata <= {16'h0000, rdView};
        s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Access control and capture registers

  wire logic evtSet = evtBus.evtValid;
  wire logic abortSet = evtBus.evtValid & evtBus.evtAbort;
  wire logic mismatchSet = evtBus.evtValid & evtBus.evtMismatch;

  always_ff @(posedge clock) begin
    if (reset) begin
      access_r <= ACCESS_RESET;
      spare_r <= SPARE_RESET;
      irqMask_r <= IRQ_MASK_RESET;
    end else begin
      access_r <= access_nxt;
      spare_r <= spare_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end

  // Set wins over the clear by read
  always_ff @(posedge clock) begin
    if (reset) begin
      abortFlag_r <= 1'b0;
      mismatchFlag_r <= 1'b0;
    end else begin
      abortFlag_r <= abortSet | (abortFlag_r & ~captureReadClr);
      mismatchFlag_r <= mismatchSet |
        (mismatchFlag_r & ~captureReadClr);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      direction_r <= DIRECTION_RESET;
      initiator_r <= INITIATOR_RESET;
    end else if (evtSet) begin
      direction_r <= evtBus.evtRead;
      initiator_r <= evtBus.evtInit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs to the bridge

  // Clock may stop only when saving is on and the bridge is idle
  always_ff @(posedge clock) begin
    if (reset) begin
      dmaAccessEnable <= ACCESS_RESET[DMA_ENABLE_BIT];
      bridgeClockRun <= 1'b1;
    end else begin
      dmaAccessEnable <= access_nxt[DMA_ENABLE_BIT];
      bridgeClockRun <= ~access_nxt[DPS_ENABLE_BIT] | accBusy |
        accDone;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Submodules

  pbac_access_monitor u_monitor (
    .clock(clock),
    .reset(reset),
    .accDone(accDone),
    .accAbort(accAbort),
    .accRead(accRead),
    .accInit(accInit),
    .memSize(memSize),
    .periphSize(periphSize),
    .dmaEnable(access_r[DMA_ENABLE_BIT]),
    .dmaMask(access_r[DMA_MASK_BIT]),
    .icMask(access_r[IC_MASK_BIT]),
    .cpuAbortResp(cpuAbortResp),
    .dmaAbortResp(dmaAbortResp),
    .icAbortResp(icAbortResp),
    .evt(evtBus.source)
  );

  pbac_irq_unit u_irq (
    .clock(clock),
    .reset(reset),
    .setBits({mismatchSet, abortSet}),
    .readClear(irqReadClr),
    .mask(irqMask_r),
    .status(irqStatus),
    .irq(irq)
  );
endmodule : pbac_bridge_ctrl
`default_nettype wire

/* File: verification/pbac_bridge_ctrl_assertions.sv */
// Port-level checks for the bridge abort and access control block
`timescale 1ns/1ps
`default_nettype none
module pbac_bridge_ctrl_assertions
  import pbac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Bridge report
  input wire logic accDone,
  input wire logic accAbort,
  input wire logic [1:0] accInit,
  input wire logic accBusy,
  // Answers and controls
  input wire logic cpuAbortResp,
  input wire logic dmaAbortResp,
  input wire logic icAbortResp,
  input wire logic dmaAccessEnable,
  input wire logic bridgeClockRun,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence cpuAbortSeen;
    accDone && accAbort && accInit == INIT_CPU;
  endsequence
  sequence readTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence readHeld;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  AST_CPU_ANSWER: assert property (
    cpuAbortSeen |=> cpuAbortResp)
    else $error("core abort answer missing");
  AST_DMA_CAUSE: assert property (
    dmaAbortResp |-> $past(accDone) && $past(accInit) == INIT_DMA &&
      ($past(accAbort) || !$past(dmaAccessEnable)))
    else $error("dma abort answer without cause");
  AST_IC_CAUSE: assert property (
    icAbortResp |-> $past(accDone && accAbort) && $past(accInit) == INIT_IC)
    else $error("interconnect abort answer without cause");
  AST_ONE_ANSWER: assert property (
    $onehot0({cpuAbortResp, dmaAbortResp, icAbortResp}))
    else $error("abort answer to several initiators");
  AST_CLOCK_RUN: assert property (
    accBusy || accDone |=> bridgeClockRun)
    else $error("bridge clock gated during access");
  AST_RESET_VALUES: assert property (
    $fell(reset) |-> dmaAccessEnable && bridgeClockRun && !irq)
    else $error("control outputs wrong after reset");
  AST_READ_ANSWER: assert property (
    readTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_READ_HOLD: assert property (
    readHeld |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule : pbac_bridge_ctrl_assertions
////////////////////////////////////////////////////////////////////////////////
bind pbac_bridge_ctrl pbac_bridge_ctrl_assertions chk_u (
  .clock(clock), .reset(reset),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .accDone(accDone), .accAbort(accAbort),
  .accInit(accInit), .accBusy(accBusy), .cpuAbortResp(cpuAbortResp),
  .dmaAbortResp(dmaAbortResp), .icAbortResp(icAbortResp),
  .dmaAccessEnable(dmaAccessEnable), .bridgeClockRun(bridgeClockRun),
  .irq(irq)
);
`default_nettype wire

/* File: verification/pbac_initiator_model.sv */
// Initiator side: reports bridge accesses and receives abort answers
`timescale 1ns/1ps
`default_nettype none
module pbac_initiator_model
  import pbac_pkg::*;
(
  // Clock
  input wire logic clock,
  // Bridge access report
  output logic accDone,
  output logic accAbort,
  output logic accRead,
  output logic [1:0] accInit,
  output logic [1:0] memSize,
  output logic [1:0] periphSize,
  output logic accBusy,
  // Abort answers
  input wire logic cpuAbortResp,
  input wire logic dmaAbortResp,
  input wire logic icAbortResp
);
  initial begin
    {accDone, accAbort, accRead, accInit, memSize, periphSize, accBusy} = '0;
  end
  // One access; answers sampled in the cycle after it completes
  task automatic issue(input logic ab, input logic rd, input logic [1:0] ini,
      input logic [1:0] ms, input logic [1:0] ps, output logic [2:0] ans);
    @(posedge clock);
    {accDone, accAbort, accRead, accInit, memSize, periphSize, accBusy} <=
      {1'b1, ab, rd, ini, ms, ps, 1'b1};
    @(posedge clock);
    // Stale qualifiers are shown inverted, never held
    {accDone, accAbort, accRead, accInit, memSize, periphSize, accBusy} <=
      {1'b0, ~ab, ~rd, ~ini, ~ms, ~ps, 1'b0};
    #1;
    ans = {icAbortResp, dmaAbortResp, cpuAbortResp};
  endtask : issue
endmodule : pbac_initiator_model
`default_nettype wire

/* File: verification/pbac_bridge_ctrl_test.sv */
// Self-checking bench for the bridge abort and access control block
`timescale 1ns/1ps
`default_nettype none
module pbac_bridge_ctrl_test
  import pbac_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, accInit, memSize, periphSize;
  logic accDone, accAbort, accRead, accBusy, cpuAbortResp, dmaAbortResp;
  logic icAbortResp, dmaAccessEnable, bridgeClockRun, irq;
  int badCount = 0;
  int nTests = 0;
  always #2 clock = ~clock;
  pbac_bridge_ctrl dut_u (
    .clock(clock), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .accDone(accDone), .accAbort(accAbort), .accRead(accRead),
    .accInit(accInit), .memSize(memSize), .periphSize(periphSize),
    .accBusy(accBusy), .cpuAbortResp(cpuAbortResp),
    .dmaAbortResp(dmaAbortResp), .icAbortResp(icAbortResp),
    .dmaAccessEnable(dmaAccessEnable), .bridgeClockRun(bridgeClockRun),
    .irq(irq)
  );
  pbac_initiator_model partner_u (
    .clock(clock), .accDone(accDone), .accAbort(accAbort),
    .accRead(accRead), .accInit(accInit), .memSize(memSize),
    .periphSize(periphSize), .accBusy(accBusy),
    .cpuAbortResp(cpuAbortResp), .dmaAbortResp(dmaAbortResp),
    .icAbortResp(icAbortResp)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic tallyAndFinish();
    if (badCount == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tallyAndFinish
  task automatic hang(input string what);
    badCount++;
    $display("mismatch at %0t: %s timed out", $time, what);
    tallyAndFinish();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic settle();
    @(posedge clock);
    #1;
  endtask : settle
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    int k;
    logic awOpen;
    logic wOpen;
    @(posedge clock);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    awOpen = 1'b1;
    wOpen = 1'b1;
    k = 0;
    while (awOpen || wOpen) begin
      @(posedge clock);
      if (awOpen && s_axi_awready === 1'b1) begin
        awOpen = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wOpen && s_axi_wready === 1'b1) begin
        wOpen = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      k++;
      if (k > 100) hang("write request");
    end
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge clock);
      k++;
      if (k > 200) hang("write response");
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int k;
    @(posedge clock);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= a;
    k = 0;
    do begin
      @(posedge clock);
      k++;
      if (k > 100) hang("read address");
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge clock);
      k++;
      if (k > 200) hang("read data");
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
  endtask : axiRead
  task automatic wrChk(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
    logic [1:0] resp;
    axiWrite(a, d, resp);
    chk(resp, r, "write resp");
  endtask : wrChk
  task automatic rdChk(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
    logic [31:0] got;
    logic [1:0] resp;
    axiRead(a, got, resp);
    chk(got, d, "read data");
    chk(resp, r, "read resp");
  endtask : rdChk
  //////////////////////////////////////////////////////////////////////////////
  task automatic resetValues();
    chk(dmaAccessEnable, 1'b1, "dma enable");
    chk(bridgeClockRun, 1'b1, "clock run");
    rdChk(CAPTURE_OFF, 32'h0004, RESP_OKAY);
    rdChk(ACCESS_OFF, 32'h0001, RESP_OKAY);
    rdChk(IRQ_STATUS_OFF, 32'h0, RESP_OKAY);
    rdChk(IRQ_MASK_OFF, 32'h0, RESP_OKAY);
    wrChk(CAPTURE_OFF, 32'hffff, RESP_OKAY);
    rdChk(CAPTURE_OFF, 32'hf804, RESP_OKAY);
    wrChk(CAPTURE_OFF, 32'h0, RESP_OKAY);
    rdChk(8'h40, 32'h0, RESP_SLVERR);
    wrChk(8'h40, 32'h1, RESP_SLVERR);
  endtask : resetValues
  task automatic abortIrq();
    logic [2:0] ans;
    wrChk(IRQ_MASK_OFF, 32'h1, RESP_OKAY);
    partner_u.issue(1'b1, 1'b1, INIT_DMA, 2'h2, 2'h3, ans);
    chk(ans, 3'b010, "dma answer");
    settle();
    chk(irq, 1'b1, "irq raised");
    rdChk(CAPTURE_OFF, 32'h0205, RESP_OKAY);
    rdChk(CAPTURE_OFF, 32'h0204, RESP_OKAY);
    rdChk(IRQ_STATUS_OFF, 32'h1, RESP_OKAY);
    chk(irq, 1'b0, "irq cleared");
  endtask : abortIrq
  task automatic mismatchWrite();
    logic [2:0] ans;
    partner_u.issue(1'b0, 1'b0, INIT_IC, 2'h0, 2'h2, ans);
    chk(ans, 3'b000, "no answer");
    settle();
    chk(irq, 1'b0, "mismatch masked");
    rdChk(CAPTURE_OFF, 32'h0402, RESP_OKAY);
    rdChk(CAPTURE_OFF, 32'h0400, RESP_OKAY);
    rdChk(IRQ_STATUS_OFF, 32'h2, RESP_OKAY);
  endtask : mismatchWrite
  task automatic maskSweep();
    logic [2:0] ans;
    logic [2:0] exp;
    for (int m = 0; m < 2; m++) begin
      wrChk(ACCESS_OFF, (m == 1) ? 32'h7 : 32'h1, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
        partner_u.issue(1'b1, 1'b1, 2'(i), 2'h1, 2'h1, ans);
        exp = {i == 2 && m == 0, i == 1 && m == 0, i == 0};
        chk(ans, exp, "abort answer");
        rdChk(CAPTURE_OFF, 32'h5 | (32'(i) << 9), RESP_OKAY);
      end
    end
  endtask : maskSweep
  task automatic dmaBlock();
    logic [2:0] ans;
    wrChk(ACCESS_OFF, 32'h0, RESP_OKAY);
    chk(dmaAccessEnable, 1'b0, "dma blocked");
    partner_u.issue(1'b0, 1'b0, INIT_DMA, 2'h1, 2'h1, ans);
    chk(ans, 3'b010, "blocked answer");
    rdChk(CAPTURE_OFF, 32'h0201, RESP_OKAY);
    wrChk(ACCESS_OFF, 32'h1, RESP_OKAY);
    chk(dmaAccessEnable, 1'b1, "dma allowed");
  endtask : dmaBlock
  task automatic powerSave();
    logic [2:0] ans;
    wrChk(ACCESS_OFF, 32'h9, RESP_OKAY);
    settle();
    settle();
    chk(bridgeClockRun, 1'b0, "clock gated");
    partner_u.issue(1'b0, 1'b1, INIT_CPU, 2'h2, 2'h2, ans);
    chk(bridgeClockRun, 1'b1, "clock runs");
    rdChk(ACCESS_OFF, 32'h9, RESP_OKAY);
    wrChk(ACCESS_OFF, 32'h1, RESP_OKAY);
    settle();
    chk(bridgeClockRun, 1'b1, "clock kept");
  endtask : powerSave
  task automatic midReset();
    logic [2:0] ans;
    wrChk(ACCESS_OFF, 32'h6, RESP_OKAY);
    partner_u.issue(1'b1, 1'b0, INIT_IC, 2'h0, 2'h1, ans);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    chk(irq, 1'b0, "irq after reset");
    resetValues();
  endtask : midReset
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    resetValues();
    abortIrq();
    mismatchWrite();
    maskSweep();
    dmaBlock();
    powerSave();
    midReset();
    tallyAndFinish();
  end
  initial begin
    #400000;
    hang("run");
  end
endmodule : pbac_bridge_ctrl_test
`default_nettype wire
